// ===== cfg_pkg.sv
// constants shared by the configuration register device and its host
package cfg_pkg;
  localparam int unsigned clk_mhz = 100;
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_swing = 8'h01;
  localparam logic [7:0] addr_perf = 8'h03;
  localparam logic [7:0] addr_chan_a = 8'h25;
  localparam logic [7:0] addr_coding = 8'h29;
  localparam logic [7:0] addr_chan_b = 8'h2B;
  localparam logic [7:0] addr_offset = 8'h3D;
  localparam logic [7:0] addr_pat_hi = 8'h3F;
  localparam logic [7:0] addr_pat_lo = 8'h40;
  localparam logic [7:0] addr_iface = 8'h41;
  localparam logic [7:0] addr_clkpos = 8'h42;
  localparam logic [7:0] addr_power = 8'h45;
  localparam logic [7:0] addr_swing_en = 8'hF1;
  localparam logic [7:0] reg_reset_val = 8'h00;
  // writable-bit masks: reserved bits store nothing and read zero
  localparam logic [7:0] mask_ctrl = 8'h01;
  localparam logic [7:0] mask_swing = 8'hFC;
  localparam logic [7:0] mask_perf = 8'h03;
  localparam logic [7:0] mask_chan = 8'hF7;
  localparam logic [7:0] mask_coding = 8'h18;
  localparam logic [7:0] mask_offset = 8'h20;
  localparam logic [7:0] mask_pat_hi = 8'h3F;
  localparam logic [7:0] mask_all = 8'hFF;
  localparam logic [7:0] mask_clkpos = 8'hF8;
  localparam logic [7:0] mask_power = 8'h80;
  localparam logic [7:0] mask_swing_en = 8'h03;
  localparam int unsigned bit_soft_reset = 1;
  localparam int unsigned bit_readout = 0;
  localparam int unsigned bit_offset_on = 5;
  localparam int unsigned bit_digital_on = 3;
  localparam int unsigned bit_standby = 7;
  localparam logic [1:0] perf_default = 2'b00;
  localparam logic [1:0] perf_best = 2'b11;
  localparam logic [1:0] coding_offset_binary = 2'b11;
  localparam logic [1:0] iface_parallel = 2'b11;
  localparam logic [1:0] obuf_off_b = 2'b01;
  localparam logic [1:0] obuf_off_a = 2'b10;
  localparam logic [1:0] obuf_off_all = 2'b11;
  localparam logic [1:0] edge_se_forbidden = 2'b10;
  localparam logic [5:0] swing_default = 6'b000000;
  localparam logic [3:0] gain_max = 4'b1100;
  localparam logic [2:0] pat_normal = 3'b000;
  localparam logic [2:0] pat_zeros = 3'b001;
  localparam logic [2:0] pat_ones = 3'b010;
  localparam logic [2:0] pat_toggle = 3'b011;
  localparam logic [2:0] pat_ramp = 3'b100;
  localparam logic [2:0] pat_custom = 3'b101;
  localparam logic [13:0] toggle_word = 14'h2AAA;
  localparam logic [13:0] ramp_step = 14'h0001;
  localparam int unsigned wake_us = 50;
  localparam int unsigned wake_cycles = wake_us * clk_mhz;
  localparam int unsigned frame_bits = 16;
endpackage

// ===== cfg_link_if.sv
// serial configuration link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic sclk;
  logic sen_n;
  logic sdata;
  logic serial_read_pin;
  logic serial_read_oe;
  modport device (input sclk, input sen_n, input sdata, output serial_read_pin, output serial_read_oe);
  modport host (output sclk, output sen_n, output sdata, input serial_read_pin, input serial_read_oe);
endinterface
`default_nettype wire

// ===== pattern_gen.sv
// per-channel test-pattern and output-word generator
`timescale 1ns/1ps
`default_nettype none
module pattern_gen
  import cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [13:0] adc_word,
  input wire logic [2:0] pattern_select,
  input wire logic [3:0] gain_field,
  input wire logic [13:0] custom_word,
  input wire logic digital_on,
  input wire logic offset_binary,
  input wire logic powered_down,
  output logic [13:0] data_out,
  output logic [3:0] gain_applied
);
  logic [13:0] ramp;
  logic toggle_phase;
  logic [13:0] pick;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ramp <= '0;
      toggle_phase <= 1'b0;
    end else begin
      ramp <= ramp + ramp_step; // natural wrap to zero
      toggle_phase <= ~toggle_phase;
    end
  end

  always_comb begin
    pick = adc_word;
    if (digital_on) begin
      case (pattern_select)
        pat_zeros: pick = '0;
        pat_ones: pick = '1;
        pat_toggle: pick = toggle_phase ? ~toggle_word : toggle_word;
        pat_ramp: pick = ramp;
        pat_custom: pick = custom_word;
        default: pick = adc_word;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= '0;
      gain_applied <= '0;
    end else begin
      // binary coding flips the msb of the twos-complement word
      data_out <= powered_down ? '0 : (offset_binary ? {~pick[13], pick[12:0]} : pick);
      gain_applied <= digital_on ? ((gain_field > gain_max) ? gain_max : gain_field) : '0;
    end
  end
endmodule
`default_nettype wire

// ===== cfg_device.sv
// device end: serial configuration register bank and its control outputs
`timescale 1ns/1ps
`default_nettype none
// Operation
// - soft reset clears all registers, self-clears
// - readout off floats serial read pin
// - swing field selects differential output amplitude
// - host enables swing programming before nondefault swing
// - performance mode only 00 or 11
// - gain in half-decibel steps to 6 dB
// - channel A pattern select replaces data
// - channel B pattern independent, same codes
// - toggle pattern alternates word and complement
// - ramp increments by one each sample
// - custom 14-bit word from two registers
// - coding 11 offset binary, else twos complement
// - bit 5 enables offset correction loop
// - interface 11 parallel, else differential DDR
// - single-ended clock drive four strengths
// - buffer powerdown field tri-states channels, clock
// - differential falling-edge shift codes
// - differential rising-edge shift codes
// - single-ended edge shifts; code 10 forbidden
// - digital enable gates patterns, gain, offset
// - standby bit stops both channels, fast wake
// - host writes zero to reserved bits; the host keeps power bits 6, 5, 2 and passes swing enable unmasked
// - all registers zero after reset, multi-field writes
module cfg_device
  import cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  cfg_link_if.device link,
  input wire logic [13:0] adc_a,
  input wire logic [13:0] adc_b,
  output logic [13:0] data_a,
  output logic [13:0] data_b,
  output logic data_a_oe,
  output logic data_b_oe,
  output logic clock_out_oe,
  output logic [3:0] chan_a_gain_field,
  output logic [3:0] chan_b_gain_field,
  output logic [5:0] swing_code,
  output logic [1:0] performance_select_field,
  output logic offset_loop_on,
  output logic parallel_mode,
  output logic [1:0] single_ended_clock_drive,
  output logic [1:0] clock_falling_edge_shift,
  output logic [1:0] clock_rising_edge_shift,
  output logic standby_bit,
  output logic awake
);
  logic [7:0] soft_reset_and_readback;
  logic [7:0] diff_output_amplitude;
  logic [7:0] performance_select;
  logic [7:0] chan_a_gain_and_pattern;
  logic [7:0] output_coding_select;
  logic [7:0] chan_b_gain_and_pattern;
  logic [7:0] offset_loop_enable;
  logic [7:0] pattern_high_bits;
  logic [7:0] pattern_low_bits;
  logic [7:0] interface_and_buffer_ctrl;
  logic [7:0] out_clock_edge_ctrl;
  logic [7:0] power_and_drive_ctrl;
  logic [7:0] swing_enable;
  logic [2:0] sclk_sync;
  logic [1:0] sen_sync;
  logic [1:0] sdata_sync;
  logic [15:0] shift;
  logic [4:0] bit_count;
  logic [7:0] read_word;
  logic frame_done;
  logic soft_reset;
  logic sclk_rise;
  logic sclk_fall;
  logic [31:0] wake_count;
  logic [1:0] obuf;
  logic digital_on;
  logic [13:0] custom_word;
  logic [13:0] gen_a;
  logic [13:0] gen_b;
  logic [3:0] gain_a;
  logic [3:0] gain_b;
  logic [13:0] next_data_a;
  logic [13:0] next_data_b;

  // link pins are synchronised; the first stage only feeds the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_sync <= '0;
      sen_sync <= 2'b11;
      sdata_sync <= '0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      sen_sync <= {sen_sync[0], link.sen_n};
      sdata_sync <= {sdata_sync[0], link.sdata};
    end
  end
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];

  // frame: 8 address bits then 8 data bits, msb first, sampled on sclk rise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift <= '0;
      bit_count <= '0;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (sen_sync[1]) begin
        bit_count <= '0;
      end else if (sclk_rise) begin
        shift <= {shift[14:0], sdata_sync[1]};
        bit_count <= bit_count + 5'd1;
        frame_done <= (bit_count == 5'(frame_bits - 1));
      end
    end
  end

  assign soft_reset = frame_done && shift[15:8] == addr_ctrl && shift[bit_soft_reset];

  // one always_ff holds the bank; soft reset wins over any write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst || soft_reset) begin
      soft_reset_and_readback <= reg_reset_val;
      diff_output_amplitude <= reg_reset_val;
      performance_select <= reg_reset_val;
      chan_a_gain_and_pattern <= reg_reset_val;
      output_coding_select <= reg_reset_val;
      chan_b_gain_and_pattern <= reg_reset_val;
      offset_loop_enable <= reg_reset_val;
      pattern_high_bits <= reg_reset_val;
      pattern_low_bits <= reg_reset_val;
      interface_and_buffer_ctrl <= reg_reset_val;
      out_clock_edge_ctrl <= reg_reset_val;
      power_and_drive_ctrl <= reg_reset_val;
      swing_enable <= reg_reset_val;
    // while readout is on only the control register takes writes, so a read frame cannot clobber the bank
    end else if (frame_done && (!soft_reset_and_readback[bit_readout] || shift[15:8] == addr_ctrl)) begin
      case (shift[15:8])
        addr_ctrl: soft_reset_and_readback <= shift[7:0] & mask_ctrl;
        addr_swing: diff_output_amplitude <= shift[7:0] & mask_swing;
        addr_perf: performance_select <= shift[7:0] & mask_perf;
        addr_chan_a: chan_a_gain_and_pattern <= shift[7:0] & mask_chan;
        addr_coding: output_coding_select <= shift[7:0] & mask_coding;
        addr_chan_b: chan_b_gain_and_pattern <= shift[7:0] & mask_chan;
        addr_offset: offset_loop_enable <= shift[7:0] & mask_offset;
        addr_pat_hi: pattern_high_bits <= shift[7:0] & mask_pat_hi;
        addr_pat_lo: pattern_low_bits <= shift[7:0] & mask_all;
        addr_iface: interface_and_buffer_ctrl <= shift[7:0] & mask_all;
        addr_clkpos: out_clock_edge_ctrl <= shift[7:0] & mask_clkpos;
        addr_power: power_and_drive_ctrl <= shift[7:0] & mask_power;
        addr_swing_en: swing_enable <= shift[7:0] & mask_swing_en;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (shift[7:0])
      addr_ctrl: read_word = soft_reset_and_readback;
      addr_swing: read_word = diff_output_amplitude;
      addr_perf: read_word = performance_select;
      addr_chan_a: read_word = chan_a_gain_and_pattern;
      addr_coding: read_word = output_coding_select;
      addr_chan_b: read_word = chan_b_gain_and_pattern;
      addr_offset: read_word = offset_loop_enable;
      addr_pat_hi: read_word = pattern_high_bits;
      addr_pat_lo: read_word = pattern_low_bits;
      addr_iface: read_word = interface_and_buffer_ctrl;
      addr_clkpos: read_word = out_clock_edge_ctrl;
      addr_power: read_word = power_and_drive_ctrl;
      addr_swing_en: read_word = swing_enable;
      default: read_word = '0;
    endcase
  end

  // readback: after 8 address bits, data shifts out msb first on sclk fall
  logic [7:0] read_shift;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_shift <= '0;
      link.serial_read_pin <= 1'b0;
      link.serial_read_oe <= 1'b0;
    end else begin
      link.serial_read_oe <= soft_reset_and_readback[bit_readout] & ~sen_sync[1];
      if (sclk_fall && bit_count == 5'd8) begin
        read_shift <= {read_word[6:0], 1'b0};
        link.serial_read_pin <= read_word[7];
      end else if (sclk_fall && bit_count > 5'd8) begin
        read_shift <= {read_shift[6:0], 1'b0};
        link.serial_read_pin <= read_shift[7];
      end
    end
  end

  // standby wake timer: awake rises a fixed time after standby clears
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_count <= '0;
      awake <= 1'b1;
    end else if (power_and_drive_ctrl[bit_standby]) begin
      wake_count <= '0;
      awake <= 1'b0;
    end else if (!awake) begin
      wake_count <= wake_count + 32'd1;
      awake <= (wake_count == 32'(wake_cycles - 1));
    end
  end

  assign obuf = interface_and_buffer_ctrl[1:0];
  assign digital_on = out_clock_edge_ctrl[bit_digital_on];
  assign custom_word = {pattern_high_bits[5:0], pattern_low_bits};

  pattern_gen gen_a_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .adc_word(adc_a),
    .pattern_select(chan_a_gain_and_pattern[2:0]), .gain_field(chan_a_gain_and_pattern[7:4]),
    .custom_word(custom_word), .digital_on(digital_on),
    .offset_binary(output_coding_select[4:3] == coding_offset_binary),
    .powered_down(~awake), .data_out(gen_a), .gain_applied(gain_a)
  );
  pattern_gen gen_b_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .adc_word(adc_b),
    .pattern_select(chan_b_gain_and_pattern[2:0]), .gain_field(chan_b_gain_and_pattern[7:4]),
    .custom_word(custom_word), .digital_on(digital_on),
    .offset_binary(output_coding_select[4:3] == coding_offset_binary),
    .powered_down(~awake), .data_out(gen_b), .gain_applied(gain_b)
  );
  assign next_data_a = gen_a;
  assign next_data_b = gen_b;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_a <= '0;
      data_b <= '0;
      data_a_oe <= 1'b0;
      data_b_oe <= 1'b0;
      clock_out_oe <= 1'b0;
      chan_a_gain_field <= '0;
      chan_b_gain_field <= '0;
      swing_code <= '0;
      performance_select_field <= '0;
      offset_loop_on <= 1'b0;
      parallel_mode <= 1'b0;
      single_ended_clock_drive <= '0;
      clock_falling_edge_shift <= '0;
      clock_rising_edge_shift <= '0;
      standby_bit <= 1'b0;
    end else begin
      data_a <= next_data_a;
      data_b <= next_data_b;
      data_a_oe <= obuf != obuf_off_a && obuf != obuf_off_all;
      data_b_oe <= obuf != obuf_off_b && obuf != obuf_off_all;
      clock_out_oe <= obuf != obuf_off_all;
      chan_a_gain_field <= gain_a;
      chan_b_gain_field <= gain_b;
      // swing only takes a nondefault code once programming is enabled
      swing_code <= (swing_enable != '0) ? diff_output_amplitude[7:2] : swing_default;
      performance_select_field <= (performance_select[1:0] == perf_best) ? perf_best : perf_default;
      offset_loop_on <= offset_loop_enable[bit_offset_on] & digital_on;
      parallel_mode <= interface_and_buffer_ctrl[7:6] == iface_parallel;
      single_ended_clock_drive <= interface_and_buffer_ctrl[5:4];
      clock_falling_edge_shift <= out_clock_edge_ctrl[7:6];
      clock_rising_edge_shift <= out_clock_edge_ctrl[5:4];
      standby_bit <= power_and_drive_ctrl[bit_standby];
    end
  end
endmodule
`default_nettype wire

// ===== cfg_host.sv
// host end: Avalon-MM command registers driving the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module cfg_host
  import cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  cfg_link_if.host link,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // word 0: command {read[16], addr[15:8], data[7:0]}, write starts a frame
  // word 1: status {busy[8], last read byte[7:0]}
  localparam logic [1:0] host_cmd = 2'd0;
  localparam logic [1:0] host_status = 2'd1;
  localparam int unsigned cmd_read_bit = 16;
  localparam int unsigned half_period = 4;
  typedef enum {idle, shifting, finish} host_state_t;
  host_state_t state;
  logic [15:0] frame;
  logic [4:0] bits_left;
  logic [2:0] div;
  logic [7:0] rx;
  logic busy;
  logic [7:0] safe_data;

  // reserved bits cleared except in the power and swing enable bytes; forbidden performance codes replaced by the default 00
  always_comb begin
    safe_data = avs_writedata[7:0];
    case (avs_writedata[15:8])
      addr_ctrl: safe_data = avs_writedata[7:0] & mask_ctrl | (avs_writedata[7:0] & 8'h02);
      addr_perf: safe_data = (avs_writedata[1:0] == perf_best) ? 8'h03 : 8'h00;
      addr_chan_a, addr_chan_b: safe_data = avs_writedata[7:0] & mask_chan;
      addr_coding: safe_data = avs_writedata[7:0] & mask_coding;
      addr_offset: safe_data = avs_writedata[7:0] & mask_offset;
      addr_pat_hi: safe_data = avs_writedata[7:0] & mask_pat_hi;
      addr_iface: safe_data = avs_writedata[7:0] & 8'hF3;
      addr_clkpos: safe_data = avs_writedata[7:0] & mask_clkpos; // software avoids 10 in parallel mode
      addr_power: safe_data = avs_writedata[7:0] & 8'hE4;
      addr_swing: safe_data = avs_writedata[7:0] & mask_swing;
      default: safe_data = avs_writedata[7:0];
    endcase
  end

  assign busy = state != idle;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      // answer one cycle after the request; writes to command stall while busy
      avs_waitrequest <= ~(((avs_read || avs_write) && avs_waitrequest && !(avs_write && busy)));
      if (avs_read && avs_waitrequest)
        avs_readdata <= (avs_address == host_status) ? {23'd0, busy, rx} : 32'd0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= idle;
      frame <= '0;
      bits_left <= '0;
      div <= '0;
      rx <= '0;
      link.sclk <= 1'b0;
      link.sen_n <= 1'b1;
      link.sdata <= 1'b0;
    end else begin
      case (state)
        idle: begin
          if (avs_write && avs_waitrequest && !busy && avs_address == host_cmd) begin
            // swing enable sent as is, swing code masked to bits 7:2; software sets swing enable first
            frame <= {avs_writedata[15:8], avs_writedata[cmd_read_bit] ? 8'h00 : safe_data};
            bits_left <= 5'(frame_bits);
            div <= '0;
            link.sen_n <= 1'b0;
            link.sdata <= avs_writedata[15];
            state <= shifting;
          end
        end
        shifting: begin
          div <= div + 3'd1;
          if (div == 3'(half_period - 1)) begin
            div <= '0;
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
              frame <= {frame[14:0], 1'b0};
              link.sdata <= frame[14];
              bits_left <= bits_left - 5'd1;
              if (bits_left == 5'd1)
                state <= finish;
            end else if (bits_left <= 5'd8) begin
              rx <= {rx[6:0], link.serial_read_pin};
            end
          end
        end
        finish: begin
          link.sen_n <= 1'b1;
          link.sdata <= 1'b0;
          state <= idle;
        end
        default: state <= idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== cfg_link_monitor.sv
// wire checks on the configuration link between host and device
`timescale 1ns/1ps
`default_nettype none
module cfg_link_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sen_n,
  input wire logic sdata,
  input wire logic serial_read_pin,
  input wire logic serial_read_oe
);
  logic sclk_d;
  logic [4:0] rises;
  logic [15:0] shift;
  logic readout_q;
  wire rise = sclk && !sclk_d && !sen_n;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
      rises <= 5'h0;
      shift <= 16'h0;
    end else begin
      sclk_d <= sclk;
      rises <= sen_n ? 5'h0 : rises + 5'(rise);
      if (rise) begin
        shift <= {shift[14:0], sdata};
      end
    end
  end
  // readout follows frames to address 00; the reset bit clears it with the rest of the bank
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readout_q <= 1'b0;
    end else if (!sen_n && rises == 5'h10 && shift[15:8] == 8'h00) begin
      readout_q <= shift[0] && !shift[1];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_sclk_in_frame: assert property ($rose(sclk) |-> !sen_n)
    else $error("sclk rose outside a frame");
  a_sixteen_rises: assert property ($rose(sen_n) |-> rises == 5'h10)
    else $error("frame closed without sixteen clock rises");
  a_frame_length: assert property ($fell(sen_n) |-> ##[64:400] $rose(sen_n))
    else $error("frame did not close in time");
  a_sclk_spacing: assert property ($rose(sclk) |=> (!$rose(sclk)) [*3])
    else $error("serial clock too fast");
  a_data_settled: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("data moved at the clock rise");
  a_sclk_still: assert property (sen_n && $past(sen_n) |-> $stable(sclk))
    else $error("serial clock moved between frames");
  a_frame_start: assert property ($fell(sen_n) |-> !sclk)
    else $error("frame opened with clock high");
  a_read_floats: assert property (!readout_q && !$past(readout_q, 6) |-> !serial_read_oe)
    else $error("read pin driven with readout off");
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench: host and device joined over the configuration link
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module tb;
  import cfg_pkg::*;
  localparam logic [1:0] status_word = 2'h1; // host status word with busy in bit 8
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] adc_a = 14'h0123;
  logic [13:0] adc_b = 14'h0456;
  logic [13:0] data_a, data_b;
  logic data_a_oe, data_b_oe, clock_out_oe, offset_loop_on, parallel_mode, standby_bit, awake;
  logic [3:0] chan_a_gain_field, chan_b_gain_field;
  logic [5:0] swing_code;
  logic [1:0] performance_select_field, single_ended_clock_drive, clock_falling_edge_shift, clock_rising_edge_shift;
  logic [15:0] frame;
  int n_fail = 0;
  int check_count = 0;
  cfg_link_if link();
  cfg_device i_cfg_device (.core_clk, .sys_rst, .link(link), .adc_a, .adc_b, .data_a, .data_b, .data_a_oe,
    .data_b_oe, .clock_out_oe, .chan_a_gain_field, .chan_b_gain_field, .swing_code, .performance_select_field,
    .offset_loop_on, .parallel_mode, .single_ended_clock_drive, .clock_falling_edge_shift,
    .clock_rising_edge_shift, .standby_bit, .awake);
  cfg_host i_cfg_host (.core_clk, .sys_rst, .link(link), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  cfg_link_monitor i_cfg_link_monitor (.core_clk, .sys_rst, .sclk(link.sclk), .sen_n(link.sen_n),
    .sdata(link.sdata), .serial_read_pin(link.serial_read_pin), .serial_read_oe(link.serial_read_oe));
  always @(posedge link.sclk) if (!link.sen_n) frame <= {frame[14:0], link.sdata};
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 100) begin n_fail++; give_verdict(); end
  endtask
  // issue one command word, then poll busy so the next one never stalls the bus
  task automatic cmd(input logic [31:0] w, output logic [7:0] b);
    logic [31:0] q;
    int n;
    bus(2'h0, 1'b1, w, q);
    n = 0;
    do begin
      bus(status_word, 1'b0, 32'h0, q);
      n++;
    end while (q[8] !== 1'b0 && n < 200);
    b = q[7:0];
    if (n == 200) begin n_fail++; give_verdict(); end
    repeat (6) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wrx(a, d, d);
  endtask
  // f is the byte the host must put on the link once reserved bits and forbidden codes are cleared
  task automatic wrx(input logic [7:0] a, input logic [7:0] d, input logic [7:0] f);
    logic [7:0] b;
    cmd({16'h0, a, d}, b);
    `CHK("frame", {a, f}, frame)
  endtask
  // readout stays off outside reads, since writes may be blocked while it is on
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    wr(addr_ctrl, 8'h01);
    cmd({15'h0, 1'b1, a, 8'h00}, b);
    wr(addr_ctrl, 8'h00);
  endtask
  task automatic t_reset();
    `CHK("reset", 15'h0001, {swing_code, performance_select_field, chan_a_gain_field, offset_loop_on, standby_bit, awake})
  endtask
  task automatic t_swing();
    wr(addr_swing, 8'hF8);
    `CHK("swing locked", swing_default, swing_code)
    wr(addr_swing_en, 8'h03);
    wr(addr_swing, 8'hF8);
    `CHK("swing low", 6'b111110, swing_code)
    wr(addr_swing, 8'h6C);
    `CHK("swing up", 6'b011011, swing_code)
  endtask
  task automatic t_perf();
    for (int i = 0; i < 4; i++) begin
      wrx(addr_perf, 8'(i), (i == 3) ? {6'h0, perf_best} : {6'h0, perf_default});
      `CHK("perf", (i == 3) ? perf_best : perf_default, performance_select_field)
    end
  endtask
  task automatic t_digital();
    wr(addr_chan_a, 8'hD0);
    `CHK("gain off", 4'h0, chan_a_gain_field)
    wr(addr_clkpos, 8'hD8);
    `CHK("edges", 4'hD, {clock_falling_edge_shift, clock_rising_edge_shift})
    `CHK("gain clamp", gain_max, chan_a_gain_field)
    wr(addr_chan_b, 8'h50);
    `CHK("gain b", 8'hC5, {chan_a_gain_field, chan_b_gain_field})
    `CHK("normal", adc_b, data_b)
  endtask
  task automatic t_patterns();
    logic [13:0] w;
    int n;
    wr(addr_pat_hi, 8'h2B);
    wr(addr_pat_lo, 8'hCD);
    wr(addr_chan_b, {5'h0, pat_custom});
    wr(addr_chan_a, {5'h0, pat_zeros});
    `CHK("zeros", 28'h0002BCD, {data_a, data_b})
    wr(addr_chan_a, {5'h0, pat_ones});
    `CHK("ones", 14'h3FFF, data_a)
    wr(addr_chan_a, {5'h0, pat_toggle});
    w = data_a;
    @(posedge core_clk);
    `CHK("toggle", 1'b1, (w === toggle_word || w === ~toggle_word) && data_a === ~w)
    wr(addr_chan_a, {5'h0, pat_ramp});
    w = data_a;
    @(posedge core_clk);
    `CHK("ramp step", w + ramp_step, data_a)
    n = 0;
    while (data_a !== 14'h3FFF && n < 17000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 17000) begin n_fail++; give_verdict(); end
    @(posedge core_clk);
    `CHK("ramp wrap", 14'h0000, data_a)
    wr(addr_coding, 8'h18);
    wr(addr_chan_a, {5'h0, pat_zeros});
    `CHK("offset binary", 14'h2000, data_a)
    wr(addr_coding, 8'h00);
  endtask
  task automatic t_iface();
    logic [1:0] o;
    for (int i = 0; i < 4; i++) begin
      o = i[1:0];
      wr(addr_iface, {6'b111000, o});
      `CHK("iface", 3'b110, {parallel_mode, single_ended_clock_drive})
      `CHK("buffers", {~o[1], ~o[0], o != 2'b11}, {data_a_oe, data_b_oe, clock_out_oe})
    end
    wr(addr_iface, 8'h80);
    `CHK("ddr", 1'b0, parallel_mode)
  endtask
  task automatic t_offset();
    logic [7:0] b;
    wrx(addr_offset, 8'hFF, 8'h20);
    `CHK("offset on", 1'b1, offset_loop_on)
    rd(addr_offset, b);
    `CHK("readback", 8'h20, b)
  endtask
  task automatic t_standby();
    int n;
    wr(addr_power, 8'h80);
    `CHK("standby", 15'h4000, {standby_bit, data_b})
    wr(addr_power, 8'h00);
    n = 0;
    while (awake !== 1'b1 && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 6000) begin n_fail++; give_verdict(); end
    `CHK("wake time", 1'b1, n > wake_cycles - 400 && n < wake_cycles)
  endtask
  task automatic t_soft_reset();
    logic [7:0] b;
    wr(addr_ctrl, 8'h02);
    `CHK("soft reset", 7'h0, {swing_code, offset_loop_on})
    rd(addr_offset, b);
    `CHK("cleared", 8'h00, b)
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_swing();
    t_perf();
    t_digital();
    t_patterns();
    t_iface();
    t_offset();
    t_standby();
    t_soft_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
